/* File: rtl/cemb_mask_bank.v */
// die temperature flags and interrupt mask registers of the charger event logic
// Notes on behaviour
// [R1] The second thermal level flag is a read-only live mirror, untouched by reset, default 0.
// [R2] Bit 1 at location 09 reads 1 while the die is above the first thermal level.
// [R3] Bit 0 at location 09 reads 1 while the die is above the warning level, else 0.
// [R4] Bits 5 to 2 at 0A mask warning, first, second and shutdown events, reset to 1.
// [R5] Bit 0 at 0A masks input-valid, reset to 1 also on on-the-go entry.
// [R6] Bits 4 to 1 at 0B mask input low, input high, battery removed, buck overvoltage, reset 1.
// [R7] Bits 7 and 4 at 0C mask battery hot and battery cold, reset to 1 incl. on-the-go entry.
// [R8] Bits 3, 2, 1 at 0C mask watchdog, USB and charge timeouts, cleared by every reset source.
// [R9] The temperature sense register also shows a live thermal shutdown flag.
// [R10] A mask bit at 1 stops its event from raising the interrupt; at 0 it passes.
// [R11] Reserved bits read zero and writes to them change nothing.
`timescale 1ns/1ps
`include "cemb_defines.vh"

module cemb_mask_bank (
  input wire mclk_i,
  input wire resetn_i,
  input wire off_state_i,
  input wire reg_reset_i,
  input wire on_the_go_mode_entry_i,
  input wire thermal_warn_cmp_i,
  input wire thermal_level_one_cmp_i,
  input wire thermal_level_two_cmp_i,
  input wire thermal_shutdown_cmp_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire [13:0] event_i,
  output reg [7:0] reg_rdata_o,
  output reg [13:0] event_pass_o,
  output reg irq_o
);

  // comparator samples, three stages; no reset so the flags stay live
  reg [3:0] cmp_s1;
  reg [3:0] cmp_s2;
  reg [3:0] cmp_s3;
  wire [3:0] stage_agree;
  wire [3:0] thermal_flags;
  // mask registers and their next values
  reg [7:0] status_event_mask;
  reg [7:0] charger_fault_mask_one;
  reg [7:0] charger_fault_mask_two;
  reg [7:0] next_status_mask;
  reg [7:0] next_chg_one;
  reg [7:0] next_chg_two;
  // read and event paths
  reg [7:0] next_rdata;
  reg [13:0] mask_vec;
  reg [13:0] next_event_pass;
  reg next_irq;
  wire [3:0] cmp_raw;
  wire any_reset;
  // decoded write strokes
  wire wr_status;
  wire wr_chg_one;
  wire wr_chg_two;
  // named flags of the temperature sense register
  wire thermal_warn_flag;
  wire thermal_level_one_flag;
  wire thermal_level_two_flag;
  wire thermal_shutdown_flag;
  wire [7:0] temp_sense_byte;
  // one mask bit per event source
  wire thermal_warn_irq_mask;
  wire thermal_level_one_irq_mask;
  wire thermal_level_two_irq_mask;
  wire thermal_shutdown_irq_mask;
  wire input_valid_irq_mask;
  wire input_low_irq_mask;
  wire input_high_irq_mask;
  wire battery_removed_irq_mask;
  wire buck_overvoltage_irq_mask;
  wire battery_hot_irq_mask;
  wire battery_cold_irq_mask;
  wire watchdog_timeout_irq_mask;
  wire usb_timeout_irq_mask;
  wire charge_timeout_irq_mask;

  // raw comparator levels, one bit per threshold
  assign cmp_raw = {thermal_shutdown_cmp_i, thermal_level_two_cmp_i,
                    thermal_level_one_cmp_i, thermal_warn_cmp_i};
  // any of the three reset sources restores the masks
  // off state and register reset leave the registered outputs alone
  assign any_reset = !resetn_i || off_state_i || reg_reset_i;

  // synchroniser chain, stage one takes the raw comparator levels
  // [R1] live flags, no reset
  always @(posedge mclk_i) begin
    cmp_s1 <= cmp_raw;
  end

  // stage two, the first stage that is read
  always @(posedge mclk_i) begin
    cmp_s2 <= cmp_s1;
  end

  // stage three, compared with stage two before a flag may change
  always @(posedge mclk_i) begin
    cmp_s3 <= cmp_s2;
  end

  // agreement of stages two and three, per comparator
  assign stage_agree = ~(cmp_s2 ^ cmp_s3);

  // a flag changes only once stages two and three agree
  // [R9] shutdown flag mirrored
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
      // one filtered flag per comparator, no reset so it stays live
      reg flag;
      always @(posedge mclk_i) begin
        if (stage_agree[gi]) begin
          flag <= cmp_s3[gi];
        end
      end
      assign thermal_flags[gi] = flag;
    end
  endgenerate

  // names of the filtered flags
  // [R3] warning level flag
  assign thermal_warn_flag = thermal_flags[`CEMB_BIT_THERMAL_WARN];
  // [R2] first level flag
  assign thermal_level_one_flag = thermal_flags[`CEMB_BIT_THERMAL_ONE];
  // [R1] second level flag
  assign thermal_level_two_flag = thermal_flags[`CEMB_BIT_THERMAL_TWO];
  // [R9] shutdown flag
  assign thermal_shutdown_flag = thermal_flags[`CEMB_BIT_THERMAL_SHUTDOWN];

  // temperature sense byte, upper four bits reserved
  // [R11] reserved bits read zero
  assign temp_sense_byte = {4'h0, thermal_shutdown_flag, thermal_level_two_flag,
                            thermal_level_one_flag, thermal_warn_flag};

  // write strokes, one per mask register; 09 and unmapped addresses select nothing
  // [R11] ignored write targets
  assign wr_status = reg_wr_i && (reg_addr_i == `CEMB_ADDR_STATUS_MASK);
  assign wr_chg_one = reg_wr_i && (reg_addr_i == `CEMB_ADDR_CHG_MASK_ONE);
  assign wr_chg_two = reg_wr_i && (reg_addr_i == `CEMB_ADDR_CHG_MASK_TWO);

  // status mask next value: reset sources beat on-the-go entry, which beats a write
  // [R4] thermal masks reset high
  always @* begin
    next_status_mask = status_event_mask;
    if (any_reset) begin
      next_status_mask = `CEMB_STATUS_MASK_RST; // all writable bits back to 1
    end else if (on_the_go_mode_entry_i) begin
      // [R5] input-valid mask back to 1
      next_status_mask = status_event_mask | `CEMB_STATUS_OTG_BITS;
    end else if (wr_status) begin
      // [R11] reserved bits never stored
      next_status_mask = reg_wdata_i & `CEMB_STATUS_MASK_RW;
    end
  end

  // charger mask one next value, on-the-go entry acts as a full reset here
  // [R6] charger masks reset high
  always @* begin
    next_chg_one = charger_fault_mask_one;
    if (any_reset) begin
      next_chg_one = `CEMB_CHG_ONE_RST;
    end else if (on_the_go_mode_entry_i) begin
      next_chg_one = `CEMB_CHG_ONE_RST; // on-the-go entry restores every bit
    end else if (wr_chg_one) begin
      // [R11] reserved bits never stored
      next_chg_one = reg_wdata_i & `CEMB_CHG_ONE_RW;
    end
  end

  // charger mask two next value, hot and cold to 1 and timeouts to 0 on any reset
  // [R7] [R8] mixed reset values
  always @* begin
    next_chg_two = charger_fault_mask_two;
    if (any_reset) begin
      next_chg_two = `CEMB_CHG_TWO_RST;
    end else if (on_the_go_mode_entry_i) begin
      next_chg_two = `CEMB_CHG_TWO_RST; // same values as the other reset sources
    end else if (wr_chg_two) begin
      // [R11] reserved bits never stored
      next_chg_two = reg_wdata_i & `CEMB_CHG_TWO_RW;
    end
  end

  // status mask register
  // [R4] [R5] held between updates
  always @(posedge mclk_i) begin
    status_event_mask <= next_status_mask;
  end

  // charger mask register one
  // [R6] held between updates
  always @(posedge mclk_i) begin
    charger_fault_mask_one <= next_chg_one;
  end

  // charger mask register two
  // [R7] [R8] held between updates
  always @(posedge mclk_i) begin
    charger_fault_mask_two <= next_chg_two;
  end

  // read data decode, unmapped and reserved bits read zero
  // [R11] unmapped addresses read zero
  always @* begin
    // default covers every address outside the bank
    next_rdata = 8'h00;
    if (reg_addr_i == `CEMB_ADDR_TEMP_SENSE) begin
      // [R2] [R3] temperature sense bits
      next_rdata = temp_sense_byte;
    end else if (reg_addr_i == `CEMB_ADDR_STATUS_MASK) begin
      next_rdata = status_event_mask;
    end else if (reg_addr_i == `CEMB_ADDR_CHG_MASK_ONE) begin
      next_rdata = charger_fault_mask_one;
    end else if (reg_addr_i == `CEMB_ADDR_CHG_MASK_TWO) begin
      next_rdata = charger_fault_mask_two;
    end
  end

  // each mask bit under the name of the event it gates
  // [R4] thermal event masks
  assign thermal_warn_irq_mask = status_event_mask[5];
  assign thermal_level_one_irq_mask = status_event_mask[4];
  assign thermal_level_two_irq_mask = status_event_mask[3];
  assign thermal_shutdown_irq_mask = status_event_mask[2];

  // [R5] input supply valid mask
  assign input_valid_irq_mask = status_event_mask[0];

  // [R6] input, battery removed and buck masks
  assign input_low_irq_mask = charger_fault_mask_one[4];
  assign input_high_irq_mask = charger_fault_mask_one[3];
  assign battery_removed_irq_mask = charger_fault_mask_one[2];
  assign buck_overvoltage_irq_mask = charger_fault_mask_one[1];

  // [R7] battery temperature masks
  assign battery_hot_irq_mask = charger_fault_mask_two[7];
  assign battery_cold_irq_mask = charger_fault_mask_two[4];

  // [R8] timeout masks
  assign watchdog_timeout_irq_mask = charger_fault_mask_two[3];
  assign usb_timeout_irq_mask = charger_fault_mask_two[2];
  assign charge_timeout_irq_mask = charger_fault_mask_two[1];

  // mask bits lined up with the event vector
  always @* begin
    mask_vec = 14'h0000;
    mask_vec[`CEMB_EV_WARN] = thermal_warn_irq_mask;
    mask_vec[`CEMB_EV_ONE] = thermal_level_one_irq_mask;
    mask_vec[`CEMB_EV_TWO] = thermal_level_two_irq_mask;
    mask_vec[`CEMB_EV_SHUTDOWN] = thermal_shutdown_irq_mask;
    mask_vec[`CEMB_EV_INPUT_VALID] = input_valid_irq_mask;
    mask_vec[`CEMB_EV_INPUT_LOW] = input_low_irq_mask;
    mask_vec[`CEMB_EV_INPUT_HIGH] = input_high_irq_mask;
    mask_vec[`CEMB_EV_BAT_REMOVED] = battery_removed_irq_mask;
    mask_vec[`CEMB_EV_BUCK_OVP] = buck_overvoltage_irq_mask;
    mask_vec[`CEMB_EV_BAT_HOT] = battery_hot_irq_mask;
    mask_vec[`CEMB_EV_BAT_COLD] = battery_cold_irq_mask;
    mask_vec[`CEMB_EV_WATCHDOG_TO] = watchdog_timeout_irq_mask;
    mask_vec[`CEMB_EV_USB_TO] = usb_timeout_irq_mask;
    mask_vec[`CEMB_EV_CHARGE_TO] = charge_timeout_irq_mask;
  end

  // passed events and interrupt request, before they are registered
  // [R10] masked events gated off
  always @* begin
    next_event_pass = event_i & ~mask_vec;
    next_irq = |next_event_pass;
  end

  // read data register, cleared by power-on reset only
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // passed event register
  // [R10] only unmasked events shown
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      event_pass_o <= 14'h0000;
    end else begin
      event_pass_o <= next_event_pass;
    end
  end

  // interrupt request register
  // [R10] any unmasked event raises it
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

endmodule

/* File: rtl/cemb_defines.vh */
// register offsets, field positions and reset values for the event mask bank
`ifndef CEMB_DEFINES_VH
`define CEMB_DEFINES_VH
`define CEMB_ADDR_TEMP_SENSE 8'h09
`define CEMB_ADDR_STATUS_MASK 8'h0A
`define CEMB_ADDR_CHG_MASK_ONE 8'h0B
`define CEMB_ADDR_CHG_MASK_TWO 8'h0C
// die temperature sense fields
`define CEMB_BIT_THERMAL_WARN 0
`define CEMB_BIT_THERMAL_ONE 1
`define CEMB_BIT_THERMAL_TWO 2
`define CEMB_BIT_THERMAL_SHUTDOWN 3
// writable bits of each mask register
`define CEMB_STATUS_MASK_RW 8'h3D
`define CEMB_CHG_ONE_RW 8'h1E
`define CEMB_CHG_TWO_RW 8'h9E
// reset values of the mask registers
`define CEMB_STATUS_MASK_RST 8'h3D
`define CEMB_CHG_ONE_RST 8'h1E
`define CEMB_CHG_TWO_RST 8'h90
// bits that on-the-go entry returns to reset value
`define CEMB_STATUS_OTG_BITS 8'h01
// event vector positions
`define CEMB_EV_WARN 0
`define CEMB_EV_ONE 1
`define CEMB_EV_TWO 2
`define CEMB_EV_SHUTDOWN 3
`define CEMB_EV_INPUT_VALID 4
`define CEMB_EV_INPUT_LOW 5
`define CEMB_EV_INPUT_HIGH 6
`define CEMB_EV_BAT_REMOVED 7
`define CEMB_EV_BUCK_OVP 8
`define CEMB_EV_BAT_HOT 9
`define CEMB_EV_BAT_COLD 10
`define CEMB_EV_WATCHDOG_TO 11
`define CEMB_EV_USB_TO 12
`define CEMB_EV_CHARGE_TO 13
`define CEMB_EV_COUNT 14
`endif

/* File: tb/cemb_mask_bank_monitor.sv */
// checker for the event mask bank register and event ports
`timescale 1ns/1ps
module cemb_mask_bank_monitor (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic off_state_i,
  input wire logic reg_reset_i,
  input wire logic on_the_go_mode_entry_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [13:0] event_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [13:0] event_pass_o,
  input wire logic irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // a clearing source followed by a read of one address
  sequence s_clr_rd(logic [7:0] a);
    (off_state_i || reg_reset_i) ##1 (reg_addr_i == a);
  endsequence
  sequence s_wr_rd;
    (reg_wr_i && reg_addr_i == 8'h0C && !off_state_i && !reg_reset_i
      && !on_the_go_mode_entry_i) ##1 (reg_addr_i == 8'h0C);
  endsequence
  AST_CLR_0A: assert property (s_clr_rd(8'h0A) |=> reg_rdata_o == 8'h3D)
    else $error("status mask not restored");
  AST_CLR_0B: assert property (s_clr_rd(8'h0B) |=> reg_rdata_o == 8'h1E)
    else $error("charger mask one not restored");
  AST_OTG_0C: assert property ((on_the_go_mode_entry_i ##1 reg_addr_i == 8'h0C)
    |=> reg_rdata_o == 8'h90) else $error("otg entry left mask two wrong");
  AST_WR_RSVD: assert property (s_wr_rd |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h9E))
    else $error("mask two write kept reserved bits");
  AST_TS_RSVD: assert property (reg_addr_i == 8'h09 |=> reg_rdata_o[7:4] == 4'h0)
    else $error("temperature reserved bits set");
  AST_IRQ_OR: assert property (irq_o == (|event_pass_o))
    else $error("irq differs from passed events");
  AST_PASS_SUB: assert property ((event_pass_o & ~$past(event_i)) == 14'h0000)
    else $error("event passed without source");
  AST_RST_OUT: assert property ($rose(resetn_i) |-> !irq_o && event_pass_o == 14'h0000)
    else $error("outputs active after reset");
endmodule
bind cemb_mask_bank cemb_mask_bank_monitor i_mon (.mclk_i, .resetn_i, .off_state_i,
  .reg_reset_i, .on_the_go_mode_entry_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .event_i,
  .reg_rdata_o, .event_pass_o, .irq_o);

/* File: tb/charger_event_mask_bank_test.sv */
// self-checking bench for the charger event mask bank
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t got %h want %h", $time, a, b); end end
module charger_event_mask_bank_test;
  logic mclk_i = 0, resetn_i = 0, off_state_i = 0, reg_reset_i = 0, otg = 0, reg_wr_i = 0;
  logic [3:0] cmp = 4'h0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  logic [13:0] event_i = 14'h0000;
  wire [7:0] reg_rdata_o;
  wire [13:0] event_pass_o;
  wire irq_o;
  int failures = 0, check_count = 0;
  always #12.5 mclk_i = ~mclk_i;
  cemb_mask_bank i_dut (.mclk_i, .resetn_i, .off_state_i, .reg_reset_i,
    .on_the_go_mode_entry_i(otg), .thermal_warn_cmp_i(cmp[0]), .thermal_level_one_cmp_i(cmp[1]),
    .thermal_level_two_cmp_i(cmp[2]), .thermal_shutdown_cmp_i(cmp[3]), .reg_addr_i,
    .reg_wr_i, .reg_wdata_i, .event_i, .reg_rdata_o, .event_pass_o, .irq_o);
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) begin reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1; end
    @(posedge mclk_i) reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i) reg_addr_i <= a;
    @(posedge mclk_i) #1 `CHK(reg_rdata_o, e)
  endtask
  task t_write;
    wr(8'h0A, 8'hFF); wr(8'h0B, 8'hFF); wr(8'h0C, 8'hFF); wr(8'h09, 8'hFF);
    rd(8'h0A, 8'h3D); // reserved bits dropped
    rd(8'h0C, 8'h9E); // timeout masks writable
    $display("t_write done");
  endtask
  task t_otg;
    wr(8'h0A, 8'h00); wr(8'h0B, 8'h00); wr(8'h0C, 8'h00);
    @(posedge mclk_i) begin otg <= 1'b1; reg_addr_i <= 8'h0C; end
    @(posedge mclk_i) otg <= 1'b0;
    rd(8'h0A, 8'h01); // only input valid mask set
    rd(8'h0B, 8'h1E); // charger masks set
    rd(8'h0C, 8'h90); // hot and cold set, timeouts cleared
    $display("t_otg done");
  endtask
  task t_mask;
    wr(8'h0A, 8'h00); wr(8'h0B, 8'h00); wr(8'h0C, 8'h00);
    @(posedge mclk_i) event_i <= 14'h3FFF;
    repeat (2) @(posedge mclk_i);
    #1 `CHK({irq_o, event_pass_o}, 15'h7FFF) // all unmasked
    @(posedge mclk_i) begin reg_reset_i <= 1'b1; reg_addr_i <= 8'h0A; end
    @(posedge mclk_i) reg_reset_i <= 1'b0;
    @(posedge mclk_i) #1 `CHK(event_pass_o, 14'h3800) // only timeouts pass
    wr(8'h0C, 8'h9E);
    @(posedge mclk_i) #1 `CHK({irq_o, event_pass_o}, 15'h0000) // all masked
    @(posedge mclk_i) event_i <= 14'h0000;
    $display("t_mask done");
  endtask
  task t_temp;
    @(posedge mclk_i) begin off_state_i <= 1'b1; reg_addr_i <= 8'h0B; end
    @(posedge mclk_i) off_state_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i) cmp <= 4'h5 << i;
      repeat (6) @(posedge mclk_i);
      rd(8'h09, {4'h0, 4'h5 << i});
    end
    $display("t_temp done");
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd(8'h0B, 8'h1E);
    rd(8'h0C, 8'h90);
    t_write; t_otg; t_mask; t_temp;
    give_verdict;
  end
endmodule
